// >>> verilog/smbus_config_load_control.sv
// Role and address straps, EEPROM configuration loader and done chaining.
// What this block does
// - The role strap selects bus master when floating, bus slave when pulled strongly high; low levels are reserved.
// - In master mode a low load request starts the EEPROM configuration read.
// - In master mode the done output is high while the load has failed or is unfinished.
// - In master mode the done output goes low only after a successful, complete load.
// - In slave mode the done output floats until the load request goes low, and is then driven low.
// - In slave mode a low load request holds the bus state machine and configuration registers in reset.
// - Two four-level address straps read at power-up give 16 bus addresses.
// - The calibration reference clock is passed on as a copy resampled on the system clock, three cycles late.
// - The serial clock line is both an input and an open-drain output with an external pull-up.
`timescale 1ns/1ps
module smbus_config_load_control
  import smbus_cfg_pkg::*;
#(
  parameter int         CFG_BYTES       = 16,
  parameter logic [6:0] EEPROM_DEV_ADDR = EEPROM_DEV_ADDR_DEF
) (
  input  wire logic                  sys_clk_in,
  input  wire logic                  rst_in,
  input  wire logic                  clk_en_in,
  input  wire logic [AXI_ADDR_W-1:0] axi_awaddr_in,
  input  wire logic                  axi_awvalid_in,
  output logic                       axi_awready_out,
  input  wire logic [31:0]           axi_wdata_in,
  input  wire logic [3:0]            axi_wstrb_in,
  input  wire logic                  axi_wvalid_in,
  output logic                       axi_wready_out,
  output logic [1:0]                 axi_bresp_out,
  output logic                       axi_bvalid_out,
  input  wire logic                  axi_bready_in,
  input  wire logic [AXI_ADDR_W-1:0] axi_araddr_in,
  input  wire logic                  axi_arvalid_in,
  output logic                       axi_arready_out,
  output logic [31:0]                axi_rdata_out,
  output logic [1:0]                 axi_rresp_out,
  output logic                       axi_rvalid_out,
  input  wire logic                  axi_rready_in,
  input  wire logic [1:0]            bus_role_select_in,
  input  wire logic [1:0]            bus_id_strap_lo_in,
  input  wire logic [1:0]            bus_id_strap_hi_in,
  input  wire logic                  load_req_n_in,
  output logic                       load_done_n_out,
  output logic                       load_done_oe_out,
  input  wire logic                  cal_clk_in,
  output logic                       cal_clk_out,
  input  wire logic                  mgmt_serial_clock_in,
  output logic                       mgmt_serial_clock_out,
  output logic                       mgmt_serial_clock_oe_out,
  input  wire logic                  mgmt_serial_data_in,
  output logic                       mgmt_serial_data_out,
  output logic                       mgmt_serial_data_oe_out,
  output logic                       irq_out
);

  localparam int CW = $clog2(CFG_BYTES);
  localparam logic [CW-1:0] CNT_LAST = CW'(CFG_BYTES - 1);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [SYNC_W-1:0] sync_a_r;
  logic [SYNC_W-1:0] sync_b_r;
  wire  [SYNC_W-1:0] pins_raw = {load_req_n_in, bus_role_select_in, bus_id_strap_lo_in, bus_id_strap_hi_in,
                                 cal_clk_in, mgmt_serial_clock_in, mgmt_serial_data_in};

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sync_a_r <= SYNC_RST;
      sync_b_r <= SYNC_RST;
    end else if (clk_en_in) begin
      sync_a_r <= pins_raw;
      sync_b_r <= sync_a_r;
    end
  end

  wire       req_n_s = sync_b_r[9];
  wire [1:0] role_s  = sync_b_r[8:7];
  wire [3:0] addr_s  = {sync_b_r[4:3], sync_b_r[6:5]};
  wire       cal_s   = sync_b_r[2];
  wire       scl_s   = sync_b_r[1];
  wire       sda_s   = sync_b_r[0];

  // ****************************************
  // Strap capture, once per power-up
  // ****************************************
  logic [1:0] settle_r;
  logic       straps_ok_r;
  logic [1:0] role_r;
  logic [3:0] bus_addr_r;

  // The synchroniser must flush its reset value before the straps are trusted.
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      settle_r    <= 2'h0;
      straps_ok_r <= 1'b0;
      role_r      <= STRAP_STRONG_LO;
      bus_addr_r  <= 4'h0;
    end else if (clk_en_in && !straps_ok_r) begin
      settle_r <= settle_r + 2'h1;
      if (settle_r == STRAP_SETTLE_CYC) begin
        straps_ok_r <= 1'b1;
        role_r      <= role_s;
        bus_addr_r  <= addr_s;
      end
    end
  end

  wire is_master = straps_ok_r && (role_r == STRAP_FLOAT);
  wire is_slave  = straps_ok_r && (role_r == STRAP_STRONG_HI);
  wire slave_rst = is_slave && !req_n_s;

  // ****************************************
  // Register write decode
  // ****************************************
  logic                  aw_have_r;
  logic                  w_have_r;
  logic [AXI_ADDR_W-1:0] awaddr_r;
  logic [31:0]           wdata_r;
  logic                  wlane0_r;
  logic                  auto_en_r;
  logic [IRQ_W-1:0]      irq_stat_r;
  logic [IRQ_W-1:0]      irq_mask_r;

  wire aw_hs    = axi_awvalid_in && axi_awready_out;
  wire w_hs     = axi_wvalid_in && axi_wready_out;
  wire wr_do    = aw_have_r && w_have_r && !axi_bvalid_out;
  wire wr_ctrl  = wr_do && wlane0_r && (awaddr_r == REG_CTRL);
  wire wr_stat  = wr_do && wlane0_r && (awaddr_r == REG_IRQ_STAT);
  wire wr_mask  = wr_do && wlane0_r && (awaddr_r == REG_IRQ_MASK);
  wire wr_known = (awaddr_r == REG_CTRL) || (awaddr_r == REG_IRQ_STAT) || (awaddr_r == REG_IRQ_MASK);
  wire reload   = wr_ctrl && wdata_r[CTRL_RELOAD_BIT];
  wire aw_have_nxt = (aw_have_r && !wr_do) || aw_hs;
  wire w_have_nxt  = (w_have_r && !wr_do) || w_hs;

  // ****************************************
  // Loader state machine
  // ****************************************
  load_state_type    state_r;
  load_state_type    state_nxt;
  logic [1:0]        phase_r;
  logic [1:0]        phase_nxt;
  logic [QCNT_W-1:0] qcnt_r;
  logic [QCNT_W-1:0] qcnt_nxt;
  logic [3:0]        bit_r;
  logic [3:0]        bit_nxt;
  logic [1:0]        seq_r;
  logic [1:0]        seq_nxt;
  logic [7:0]        byte_r;
  logic [7:0]        byte_nxt;
  logic [CW-1:0]     cnt_r;
  logic [CW-1:0]     cnt_nxt;
  logic              nack_r;
  logic              nack_nxt;
  logic              ok_r;
  logic              ok_nxt;
  logic              scl_oe_r;
  logic              sda_oe_r;

  wire busy       = (state_r == ST_START) || (state_r == ST_TX) || (state_r == ST_RX) || (state_r == ST_STOP);
  wire stretch    = busy && (phase_r == 2'd1) && !scl_s;
  wire tick       = busy && (qcnt_r == QCNT_LAST) && !stretch;
  wire sample     = tick && (phase_r == 2'd2);
  wire last_phase = tick && (phase_r == 2'd3);
  wire [7:0] offset_byte = 8'(32'(bus_addr_r) * CFG_BYTES);
  wire cfg_we     = (state_r == ST_RX) && last_phase && (bit_r == 4'd8);
  wire ev_done    = (state_r == ST_STOP) && last_phase && ok_r;
  wire ev_fail    = (state_r == ST_STOP) && last_phase && !ok_r;

  always_comb begin
    state_nxt = state_r;
    phase_nxt = tick ? phase_r + 2'd1 : phase_r;
    qcnt_nxt  = !busy ? '0 : (tick ? '0 : ((qcnt_r == QCNT_LAST) ? qcnt_r : qcnt_r + QCNT_W'(1)));
    bit_nxt   = bit_r;
    seq_nxt   = seq_r;
    byte_nxt  = byte_r;
    cnt_nxt   = cnt_r;
    nack_nxt  = nack_r;
    ok_nxt    = ok_r;
    case (state_r)
      ST_IDLE: begin
        if (is_master && auto_en_r && !req_n_s) begin
          state_nxt = ST_START;
          seq_nxt   = 2'd0;
          cnt_nxt   = '0;
          ok_nxt    = 1'b0;
        end
      end
      ST_START: begin
        if (last_phase) begin
          state_nxt = ST_TX;
          bit_nxt   = 4'd0;
          byte_nxt  = {EEPROM_DEV_ADDR, (seq_r != 2'd0)};
        end
      end
      ST_TX: begin
        if (sample && bit_r == 4'd8) begin
          nack_nxt = sda_s;
        end
        if (last_phase) begin
          if (bit_r != 4'd8) begin
            bit_nxt  = bit_r + 4'd1;
            byte_nxt = {byte_r[6:0], 1'b0};
          end else if (nack_r) begin
            state_nxt = ST_STOP;
            ok_nxt    = 1'b0;
          end else begin
            bit_nxt = 4'd0;
            case (seq_r)
              2'd0: begin
                seq_nxt  = 2'd1;
                byte_nxt = offset_byte;
              end
              2'd1: begin
                seq_nxt   = 2'd2;
                state_nxt = ST_START;
              end
              default: begin
                state_nxt = ST_RX;
              end
            endcase
          end
        end
      end
      ST_RX: begin
        if (sample && bit_r != 4'd8) begin
          byte_nxt = {byte_r[6:0], sda_s};
        end
        if (last_phase) begin
          if (bit_r != 4'd8) begin
            bit_nxt = bit_r + 4'd1;
          end else begin
            bit_nxt = 4'd0;
            cnt_nxt = cnt_r + CW'(1);
            if (cnt_r == CNT_LAST) begin
              state_nxt = ST_STOP;
              ok_nxt    = 1'b1;
            end
          end
        end
      end
      ST_STOP: begin
        if (last_phase) begin
          state_nxt = ok_r ? ST_DONE : ST_FAIL;
        end
      end
      ST_DONE: begin
        if (reload) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_FAIL: begin
        if (reload || req_n_s) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // Line drive is derived from the next state so both lines change on the same edge.
  wire bit_level = (state_nxt == ST_TX) ? ((bit_nxt == 4'd8) || byte_nxt[7]) :
                   (state_nxt == ST_RX) ? ((bit_nxt != 4'd8) || (cnt_nxt == CNT_LAST)) : 1'b1;
  wire scl_oe_nxt = (state_nxt == ST_STOP) ? (phase_nxt == 2'd0) :
                    ((state_nxt == ST_START) || (state_nxt == ST_TX) || (state_nxt == ST_RX)) ?
                    ((phase_nxt == 2'd0) || (phase_nxt == 2'd3)) : 1'b0;
  wire sda_oe_nxt = (state_nxt == ST_STOP)  ? (phase_nxt != 2'd3) :
                    (state_nxt == ST_START) ? (phase_nxt[1]) :
                    ((state_nxt == ST_TX) || (state_nxt == ST_RX)) ? !bit_level : 1'b0;

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_r <= ST_IDLE;
      phase_r <= 2'd0;
      qcnt_r  <= '0;
      bit_r   <= 4'd0;
      seq_r   <= 2'd0;
      byte_r  <= 8'h00;
      cnt_r   <= '0;
      nack_r  <= 1'b0;
      ok_r    <= 1'b0;
    end else if (clk_en_in) begin
      state_r <= slave_rst ? ST_IDLE : state_nxt;
      phase_r <= slave_rst ? 2'd0 : phase_nxt;
      qcnt_r  <= slave_rst ? '0 : qcnt_nxt;
      bit_r   <= bit_nxt;
      seq_r   <= seq_nxt;
      byte_r  <= byte_nxt;
      cnt_r   <= cnt_nxt;
      nack_r  <= nack_nxt;
      ok_r    <= ok_nxt;
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      scl_oe_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end else if (clk_en_in) begin
      scl_oe_r <= !slave_rst && scl_oe_nxt;
      sda_oe_r <= !slave_rst && sda_oe_nxt;
    end
  end

  // ****************************************
  // Configuration store
  // ****************************************
  logic [7:0] cfg_mem [CFG_BYTES];

  for (genvar i = 0; i < CFG_BYTES; i++) begin : g_cfg
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
        cfg_mem[i] <= 8'h00;
      end else if (clk_en_in) begin
        if (slave_rst) begin
          cfg_mem[i] <= 8'h00;
        end else if (cfg_we && cnt_r == CW'(i)) begin
          cfg_mem[i] <= byte_r;
        end
      end
    end
  end

  // ****************************************
  // Done output, reference clock and interrupt
  // ****************************************
  logic done_n_r;
  logic done_oe_r;
  logic cal_r;
  logic slave_rst_q_r;
  logic irq_r;

  wire [IRQ_W-1:0] ev_vec   = {slave_rst && !slave_rst_q_r, ev_fail, ev_done};
  wire [IRQ_W-1:0] stat_nxt = (irq_stat_r & ~(wr_stat ? wdata_r[IRQ_W-1:0] : '0)) | ev_vec;

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      done_n_r      <= 1'b1;
      done_oe_r     <= 1'b0;
      cal_r         <= 1'b0;
      slave_rst_q_r <= 1'b0;
      irq_stat_r    <= '0;
      irq_r         <= 1'b0;
    end else if (clk_en_in) begin
      done_n_r      <= is_master ? (state_r != ST_DONE) : !is_slave;
      done_oe_r     <= is_master || (is_slave && !req_n_s);
      cal_r         <= cal_s;
      slave_rst_q_r <= slave_rst;
      irq_stat_r    <= stat_nxt;
      irq_r         <= |(stat_nxt & irq_mask_r);
    end
  end

  // ****************************************
  // AXI4-Lite slave
  // ****************************************
  logic        awready_r;
  logic        wready_r;
  logic        bvalid_r;
  logic [1:0]  bresp_r;
  logic        arready_r;
  logic        rvalid_r;
  logic [1:0]  rresp_r;
  logic [31:0] rdata_r;

  wire        ar_hs    = axi_arvalid_in && arready_r;
  wire        rd_cfg   = (axi_araddr_in >= REG_CFG_BASE) && ((axi_araddr_in - REG_CFG_BASE) < AXI_ADDR_W'(4 * CFG_BYTES));
  wire [CW-1:0] rd_idx = CW'((axi_araddr_in - REG_CFG_BASE) >> 2);
  wire [31:0] status_w = {21'h0, is_master && busy, state_r == ST_FAIL, state_r == ST_DONE, bus_addr_r,
                          straps_ok_r && !is_master && !is_slave, is_slave, is_master, straps_ok_r};
  wire        rd_known = rd_cfg || (axi_araddr_in == REG_CTRL) || (axi_araddr_in == REG_STATUS) ||
                         (axi_araddr_in == REG_IRQ_STAT) || (axi_araddr_in == REG_IRQ_MASK);
  wire [31:0] rd_mux   = rd_cfg ? {24'h0, cfg_mem[rd_idx]} :
                         (axi_araddr_in == REG_CTRL)     ? {31'h0, auto_en_r} :
                         (axi_araddr_in == REG_STATUS)   ? status_w :
                         (axi_araddr_in == REG_IRQ_STAT) ? {29'h0, irq_stat_r} :
                         (axi_araddr_in == REG_IRQ_MASK) ? {29'h0, irq_mask_r} : 32'h0;
  wire        bvalid_nxt = wr_do || (bvalid_r && !axi_bready_in);
  wire        rvalid_nxt = ar_hs || (rvalid_r && !axi_rready_in);

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      awaddr_r  <= '0;
      wdata_r   <= 32'h0;
      wlane0_r  <= 1'b0;
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
    end else if (clk_en_in) begin
      aw_have_r <= aw_have_nxt;
      w_have_r  <= w_have_nxt;
      awready_r <= !aw_have_nxt;
      wready_r  <= !w_have_nxt;
      bvalid_r  <= bvalid_nxt;
      if (aw_hs) begin
        awaddr_r <= axi_awaddr_in;
      end
      if (w_hs) begin
        wdata_r  <= axi_wdata_in;
        wlane0_r <= axi_wstrb_in[0];
      end
      if (wr_do) begin
        bresp_r <= wr_known ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      arready_r  <= 1'b0;
      rvalid_r   <= 1'b0;
      rresp_r    <= RESP_OKAY;
      rdata_r    <= 32'h0;
      auto_en_r  <= CTRL_AUTO_EN_RST;
      irq_mask_r <= IRQ_MASK_RST;
    end else if (clk_en_in) begin
      arready_r <= !rvalid_nxt;
      rvalid_r  <= rvalid_nxt;
      if (ar_hs) begin
        rdata_r <= rd_mux;
        rresp_r <= rd_known ? RESP_OKAY : RESP_SLVERR;
      end
      // Slave-mode reset also returns the control register to its default.
      if (slave_rst) begin
        auto_en_r <= CTRL_AUTO_EN_RST;
      end else if (wr_ctrl) begin
        auto_en_r <= wdata_r[CTRL_AUTO_EN_BIT];
      end
      if (wr_mask) begin
        irq_mask_r <= wdata_r[IRQ_W-1:0];
      end
    end
  end

  assign axi_awready_out          = awready_r;
  assign axi_wready_out           = wready_r;
  assign axi_bvalid_out           = bvalid_r;
  assign axi_bresp_out            = bresp_r;
  assign axi_arready_out          = arready_r;
  assign axi_rvalid_out           = rvalid_r;
  assign axi_rresp_out            = rresp_r;
  assign axi_rdata_out            = rdata_r;
  assign load_done_n_out          = done_n_r;
  assign load_done_oe_out         = done_oe_r;
  assign cal_clk_out              = cal_r;
  assign mgmt_serial_clock_out    = 1'b0;
  assign mgmt_serial_clock_oe_out = scl_oe_r;
  assign mgmt_serial_data_out     = 1'b0;
  assign mgmt_serial_data_oe_out  = sda_oe_r;
  assign irq_out                  = irq_r;

endmodule

// >>> pkg/smbus_cfg_pkg.sv
// Shared constants and types for the configuration loader.
package smbus_cfg_pkg;

  // ****************************************
  // Clock and bus timing
  // ****************************************
  localparam int SYS_CLK_MHZ     = 200;
  localparam int SMB_QUARTER_NS  = 2500;
  localparam int SMB_QUARTER_CYC = int'((64'(SMB_QUARTER_NS) * 64'(SYS_CLK_MHZ) + 64'd999) / 64'd1000);
  localparam int QCNT_W          = $clog2(SMB_QUARTER_CYC + 1);
  localparam logic [QCNT_W-1:0] QCNT_LAST = QCNT_W'(SMB_QUARTER_CYC - 1);
  localparam logic [1:0] STRAP_SETTLE_CYC = 2'h3;

  // ****************************************
  // Four-level strap codes from the level detector
  // ****************************************
  localparam logic [1:0] STRAP_STRONG_LO = 2'h0;
  localparam logic [1:0] STRAP_WEAK_LO   = 2'h1;
  localparam logic [1:0] STRAP_FLOAT     = 2'h2;
  localparam logic [1:0] STRAP_STRONG_HI = 2'h3;

  // Arbitrary default EEPROM bus address; override per board.
  localparam logic [6:0] EEPROM_DEV_ADDR_DEF = 7'h50;

  // ****************************************
  // Pin synchroniser layout
  // ****************************************
  localparam int SYNC_W = 10;
  // Idle levels: request and serial lines pulled up, reference clock pulled down.
  localparam logic [SYNC_W-1:0] SYNC_RST = 10'h203;

  // ****************************************
  // Register map
  // ****************************************
  localparam int AXI_ADDR_W = 8;
  localparam logic [AXI_ADDR_W-1:0] REG_CTRL     = 8'h00;
  localparam logic [AXI_ADDR_W-1:0] REG_STATUS   = 8'h04;
  localparam logic [AXI_ADDR_W-1:0] REG_IRQ_STAT = 8'h08;
  localparam logic [AXI_ADDR_W-1:0] REG_IRQ_MASK = 8'h0C;
  localparam logic [AXI_ADDR_W-1:0] REG_CFG_BASE = 8'h40;
  localparam int CTRL_AUTO_EN_BIT = 0;
  localparam int CTRL_RELOAD_BIT  = 1;
  localparam logic CTRL_AUTO_EN_RST = 1'b1;
  localparam int IRQ_W            = 3;
  localparam int IRQ_DONE_BIT     = 0;
  localparam int IRQ_FAIL_BIT     = 1;
  localparam int IRQ_SRST_BIT     = 2;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************
  // Loader state machine
  // ****************************************
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_START = 3'b001,
    ST_TX    = 3'b010,
    ST_RX    = 3'b011,
    ST_STOP  = 3'b100,
    ST_DONE  = 3'b101,
    ST_FAIL  = 3'b110
  } load_state_type;

endpackage

// >>> bench/smbus_cfg_monitor.sv
// Concurrent checks on the loader's pins.
`timescale 1ns/1ps
module smbus_cfg_monitor
  import smbus_cfg_pkg::*;
(
  input wire logic       sys_clk_in,
  input wire logic       rst_in,
  input wire logic       axi_awvalid_in,
  input wire logic       axi_bvalid_out,
  input wire logic [1:0] bus_role_select_in,
  input wire logic       load_req_n_in,
  input wire logic       load_done_n_out,
  input wire logic       load_done_oe_out,
  input wire logic       cal_clk_in,
  input wire logic       cal_clk_out,
  input wire logic       mgmt_serial_clock_out,
  input wire logic       mgmt_serial_clock_oe_out,
  input wire logic       mgmt_serial_data_out,
  input wire logic       mgmt_serial_data_oe_out
);
  logic [3:0] up_r;
  wire logic  up   = up_r == 4'hF;
  wire logic  is_m = bus_role_select_in == STRAP_FLOAT;
  wire logic  is_s = bus_role_select_in == STRAP_STRONG_HI;
  wire logic  is_r = bus_role_select_in inside {STRAP_STRONG_LO, STRAP_WEAK_LO};
  // Straps settle some cycles after reset, so the master drive, slave role and reference copy checks wait for this count.
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) up_r <= 4'h0;
    else if (!up) up_r <= up_r + 4'h1;
  end
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  sequence req_low_s;
    (up && is_s && !load_req_n_in) [*5];
  endsequence
  sequence req_high_s;
    (up && is_s && load_req_n_in) [*5];
  endsequence
  res_idle_a: assert property (is_r |-> !load_done_oe_out && !mgmt_serial_clock_oe_out)
    else $error("reserved role drives a pin");
  master_drive_a: assert property (up && is_m |-> load_done_oe_out && (load_done_n_out || !mgmt_serial_clock_oe_out))
    else $error("done low while loading");
  slave_follow_a: assert property (req_low_s |-> load_done_oe_out && !load_done_n_out)
    else $error("slave done not driven low");
  slave_float_a: assert property (req_high_s |-> !load_done_oe_out)
    else $error("slave done not floating");
  done_after_stop_a: assert property (is_m && $fell(load_done_n_out) |-> !mgmt_serial_clock_oe_out && !mgmt_serial_data_oe_out)
    else $error("done before bus release");
  done_hold_a: assert property (is_m && !load_done_n_out && !axi_awvalid_in && !$past(axi_awvalid_in) && !axi_bvalid_out
    |=> !load_done_n_out)
    else $error("done dropped without reload");
  open_drain_a: assert property (!mgmt_serial_clock_out && !mgmt_serial_data_out)
    else $error("serial line driven high");
  cal_copy_a: assert property (up |-> cal_clk_out == $past(cal_clk_in, 3))
    else $error("reference copy wrong");
endmodule
bind smbus_config_load_control smbus_cfg_monitor mon_u (.*);

// >>> bench/eeprom_model.sv
// Behavioural serial EEPROM answering the loader's reads.
`timescale 1ns/1ps
module eeprom_model #(
  parameter logic [6:0] DEV_ADDR = 7'h50
) (
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  input  wire logic [7:0] fill_in,
  input  wire logic       slow_in,
  output logic            scl_oe_out,
  output logic            sda_oe_out
);
  logic [7:0] b;
  logic [7:0] ptr;
  logic       m;
  task automatic get_byte();
    for (int i = 0; i < 8; i++) begin
      @(posedge scl_in);
      b = {b[6:0], sda_in};
    end
  endtask
  // Slow mode stretches the clock at each acknowledge the model sends, as a busy part would.
  task automatic ack();
    @(negedge scl_in);
    sda_oe_out = 1'b1;
    scl_oe_out = slow_in;
    #9000;
    scl_oe_out = 1'b0;
    @(negedge scl_in);
    sda_oe_out = 1'b0;
  endtask
  initial begin
    sda_oe_out = 1'b0;
    scl_oe_out = 1'b0;
    ptr = 8'h00;
    forever begin
      @(negedge sda_in iff scl_in === 1'b1);
      get_byte();
      if (b[7:1] === DEV_ADDR) begin
        ack();
        if (b[0] === 1'b0) begin
          get_byte();
          ptr = b;
          ack();
        end else begin
          do begin
            b = fill_in ^ ptr;
            for (int i = 7; i >= 0; i--) begin
              sda_oe_out = !b[i];
              @(negedge scl_in);
            end
            sda_oe_out = 1'b0;
            @(posedge scl_in);
            m = sda_in;
            ptr = ptr + 8'h01;
            if (!m) @(negedge scl_in);
          end while (!m);
        end
      end
    end
  end
endmodule

// >>> bench/tb_smbus_config_load_control.sv
// Self-checking bench for the configuration loader.
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_errors++; $display("[FAIL] %0t %h %h", $time, a, b); end end
module tb_smbus_config_load_control
  import smbus_cfg_pkg::*;
;
  logic        clk = 1'b0, rst = 1'b1, awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0, req = 1'b1, cal = 1'b0;
  logic [7:0]  aa = 8'h00, ra = 8'h00, fill = 8'h00;
  logic [31:0] wd = 32'h0;
  logic [1:0]  role = 2'h0, slo = 2'h0, shi = 2'h0;
  logic [33:0] q[$];
  logic [33:0] exp_word;
  int          n_errors = 0, num_checks = 0, seed = 58698, cyc = 0;
  wire logic   awr, wrd, bv, arr, rv, dn, doe, scloe, sdaoe, irq, mscl, msda;
  wire [1:0]   bresp, rresp;
  wire [31:0]  rdata;
  wire logic   scl = !(scloe | mscl);
  wire logic   sda = !(sdaoe | msda);
  always #2.5 clk = ~clk;
  always #20 cal = ~cal;
  smbus_config_load_control #(.CFG_BYTES(2)) dut_u (.sys_clk_in(clk), .rst_in(rst), .clk_en_in(1'b1),
    .axi_awaddr_in(aa), .axi_awvalid_in(awv), .axi_awready_out(awr), .axi_wdata_in(wd), .axi_wstrb_in(4'hF),
    .axi_wvalid_in(wv), .axi_wready_out(wrd), .axi_bresp_out(bresp), .axi_bvalid_out(bv), .axi_bready_in(br),
    .axi_araddr_in(ra), .axi_arvalid_in(arv), .axi_arready_out(arr), .axi_rdata_out(rdata),
    .axi_rresp_out(rresp), .axi_rvalid_out(rv), .axi_rready_in(rr), .bus_role_select_in(role),
    .bus_id_strap_lo_in(slo), .bus_id_strap_hi_in(shi), .load_req_n_in(req), .load_done_n_out(dn),
    .load_done_oe_out(doe), .cal_clk_in(cal), .cal_clk_out(), .mgmt_serial_clock_in(scl),
    .mgmt_serial_clock_out(), .mgmt_serial_clock_oe_out(scloe), .mgmt_serial_data_in(sda),
    .mgmt_serial_data_out(), .mgmt_serial_data_oe_out(sdaoe), .irq_out(irq));
  eeprom_model mem_u (.scl_in(scl), .sda_in(sda), .fill_in(fill), .slow_in(1'b1), .scl_oe_out(mscl),
    .sda_oe_out(msda));
  task wrap_up();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    // The queue is popped once into a variable so a mismatch report cannot consume the next note.
    if (rv && rr) begin
      exp_word = q.pop_front();
      `CHK({rresp, rdata}, exp_word)
    end
    if (cyc == 105000) begin
      n_errors++;
      wrap_up();
    end
  end
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ga, gw;
    ga = 1'b0;
    gw = 1'b0;
    @(posedge clk);
    aa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    while (!(ga && gw)) begin
      @(posedge clk);
      if (awv && awr) begin ga = 1'b1; awv <= 1'b0; end
      if (wv && wrd) begin gw = 1'b1; wv <= 1'b0; end
    end
    do @(posedge clk); while (!bv);
    br <= 1'b0;
    `CHK(bresp, er)
  endtask
  task rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk);
    ra <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    q.push_back({er, d});
    do @(posedge clk); while (!arr);
    arv <= 1'b0;
    do @(posedge clk); while (!rv);
    rr <= 1'b0;
  endtask
  task boot(input logic [1:0] r);
    rst <= 1'b1;
    role <= r;
    slo <= 2'($random(seed));
    shi <= 2'($random(seed));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (20) @(posedge clk);
  endtask
  initial begin
    fill = 8'($random(seed));
    boot({1'b0, 1'($random(seed))});
    `CHK(doe, 1'b0)
    rd(REG_STATUS, {24'h0, shi, slo, 4'h9}, RESP_OKAY);
    rd(8'h10, 32'h0, RESP_SLVERR);
    wr(8'h10, 32'h1, RESP_SLVERR);
    boot(STRAP_STRONG_HI);
    `CHK(doe, 1'b0)
    wr(REG_CTRL, 32'h0, RESP_OKAY);
    req <= 1'b0;
    repeat (10) @(posedge clk);
    `CHK({doe, dn, irq}, 3'b100)
    req <= 1'b1;
    repeat (10) @(posedge clk);
    `CHK(doe, 1'b0)
    rd(REG_CTRL, 32'h1, RESP_OKAY);
    rd(REG_IRQ_STAT, 32'h4, RESP_OKAY);
    wr(REG_IRQ_MASK, 32'h4, RESP_OKAY);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b1)
    wr(REG_IRQ_STAT, 32'h4, RESP_OKAY);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b0)
    boot(STRAP_FLOAT);
    `CHK({doe, dn}, 2'b11)
    wr(REG_IRQ_MASK, 32'h3, RESP_OKAY);
    req <= 1'b0;
    while (dn !== 1'b0) @(posedge clk);
    repeat (50) @(posedge clk);
    `CHK({doe, dn, irq}, 3'b101)
    rd(REG_CFG_BASE, {24'h0, fill ^ {3'h0, shi, slo, 1'b0}}, RESP_OKAY);
    rd(REG_CFG_BASE + 8'h04, {24'h0, fill ^ {3'h0, shi, slo, 1'b1}}, RESP_OKAY);
    rd(REG_STATUS, {21'h0, 3'b001, shi, slo, 4'h3}, RESP_OKAY);
    rd(REG_IRQ_STAT, 32'h1, RESP_OKAY);
    wrap_up();
  end
endmodule
